/* File: dv/tlvic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tlvic_core_model (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic call_req,
   input  wire logic return_from_irq_instr_go,
   input  wire logic multi,
   input  wire logic slow,
   output logic      instr_done,
   output logic      instr_multi_next,
   output logic      return_from_irq_instr_done,
   output logic      call_ack
);
   logic [2:0] busy_ff;
   logic [1:0] wait_ff;

   // Core stand-in: a boundary every other cycle, none while calling
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         instr_done       <= 1'b0;
         instr_multi_next <= 1'b0;
         return_from_irq_instr_done        <= 1'b0;
         call_ack         <= 1'b0;
         busy_ff          <= 3'h0;
         wait_ff          <= 2'h0;
      end else begin
         return_from_irq_instr_done        <= return_from_irq_instr_go;   // Routine ends by return
         instr_multi_next <= multi;     // Long instruction after a clear
         call_ack         <= 1'b0;
         instr_done       <= 1'b0;
         // Slow mode stalls the acknowledge three cycles
         if (call_req && !call_ack && busy_ff == 3'h0) begin
            if (wait_ff == (slow ? 2'h3 : 2'h0)) begin
               call_ack <= 1'b1;
               busy_ff  <= 3'h4;
               wait_ff  <= 2'h0;
            end else begin
               wait_ff <= wait_ff + 2'h1;
            end
         end else if (busy_ff != 3'h0) begin
            busy_ff <= busy_ff - 3'h1;
         end else if (!return_from_irq_instr_go && !instr_done) begin
            instr_done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/tlvic_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tlvic_ctrl_test;
   logic                   core_clk, rstn, reg_wr, reg_rd, return_from_irq_instr_go, multi, slow;
   logic [14:0]            src_event, pending;
   logic [7:0]             reg_addr, reg_wdata, reg_rdata;
   logic                   instr_done, instr_multi_next, return_from_irq_instr_done, call_req, call_ack;
   logic [1:0]             in_service;
   tlvic_pkg::tlv_req_type call_info;
   int                     n_errors, comparisons, nb, o;

   tlvic_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .src_event(src_event), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_done(instr_done), .instr_multi_next(instr_multi_next), .return_from_irq_instr_done(return_from_irq_instr_done),
      .call_req(call_req), .call_ack(call_ack), .call_info(call_info), .pending(pending),
      .in_service(in_service));
   tlvic_core_model i_core (.core_clk(core_clk), .rstn(rstn), .call_req(call_req), .return_from_irq_instr_go(return_from_irq_instr_go),
      .multi(multi), .slow(slow), .instr_done(instr_done), .instr_multi_next(instr_multi_next),
      .return_from_irq_instr_done(return_from_irq_instr_done), .call_ack(call_ack));

   // Clock, 10 ns period
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask

   // Enable and priority masks by order, global enable always on
   task automatic en(input logic [14:0] e, input logic [14:0] p);
      wr(8'ha8, {1'b1, e[6:0]});
      wr(8'he6, {e[14], 1'b0, e[12:7]});
      wr(8'hb8, {1'b0, p[6:0]});
      wr(8'hf6, {p[14], 1'b0, p[12:7]});
   endtask

   task automatic setp(input logic [14:0] e);
      wr(8'hc0, e[7:0]);
      wr(8'hc1, {1'b0, e[14:8]});
   endtask

   task automatic return_from_irq_instr();
      @(posedge core_clk);
      return_from_irq_instr_go <= 1'b1;
      @(posedge core_clk);
      return_from_irq_instr_go <= 1'b0;
   endtask

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         chk("no call", call_req, 1'b0);
      end
   endtask

   // Bounded wait for a call, counting boundaries passed meanwhile
   task automatic wait_call(input int ord, input logic hi);
      #1;
      for (int i = 0; i < 60 && call_req !== 1'b1; i++) begin
         if (instr_done === 1'b1) nb++;
         @(posedge core_clk);
         #1;
      end
      chk("call_req", call_req, 1'b1);
      chk("vector", call_info.vector, 16'(3 + 8 * ord));
      chk("order", call_info.order, 16'(ord));
      chk("high", call_info.high, hi);
      while (call_req === 1'b1) @(posedge core_clk);
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   task automatic t_reset();
      rd(8'ha8, 8'h00);
      rd(8'hb8, 8'h80);
      rd(8'hf6, 8'h00);
      rd(8'he6, 8'h00);
      rd(8'h55, 8'h00);
   endtask

   // Flag sets while blocked, then a left-set flag re-enters after one boundary
   task automatic t_gate();
      @(posedge core_clk);
      src_event <= 15'h0020;
      @(posedge core_clk);
      src_event <= 15'h0000;
      rd(8'hc0, 8'h20);
      wr(8'ha8, 8'h20);
      quiet(20);
      wr(8'ha8, 8'h80);
      quiet(20);
      wr(8'ha8, 8'ha0);
      wait_call(5, 1'b0);
      chk("kept flag", pending[5], 1'b1);
      return_from_irq_instr();
      nb = 0;
      wait_call(5, 1'b0);
      chk("boundaries", 16'(nb), 16'h2);
      setp(15'h0000);
      return_from_irq_instr();
   endtask

   // Enable clear before a long instruction costs one boundary, before a short one none
   task automatic t_clear();
      for (int m = 1; m >= 0; m--) begin
         multi <= m[0];
         wr(8'ha8, 8'h30);
         setp(15'h0020);
         wr(8'ha8, 8'ha0);
         nb = 0;
         wait_call(5, 1'b0);
         chk("boundaries", 16'(nb), 16'(1 + m));
         setp(15'h0000);
         return_from_irq_instr();
      end
   endtask

   // Every source through a software-set flag
   task automatic t_vectors();
      for (o = 0; o < 15; o++) begin
         if (o != 13) begin
            en(15'h0001 << o, 15'h0000);
            setp(15'h0001 << o);
            wait_call(o, 1'b0);
            chk("auto clear", pending[o], (o > 3) ? 1'b1 : 1'b0);
            chk("in service", in_service, 2'b01);
            setp(15'h0000);
            return_from_irq_instr();
            @(posedge core_clk);
            #1;
            chk("in service", in_service, 2'b00);
         end
      end
   endtask

   // Level first, then preemption only of a low routine, slow acknowledge
   task automatic t_prio();
      slow <= 1'b1;
      en(15'h0014, 15'h0010);
      setp(15'h0014);
      wait_call(4, 1'b1);
      chk("in service", in_service, 2'b10);
      setp(15'h0014);
      quiet(20);
      setp(15'h0004);
      return_from_irq_instr();
      wait_call(2, 1'b0);
      setp(15'h0010);
      wait_call(4, 1'b1);
      chk("in service", in_service, 2'b11);
      rd(8'hc2, 8'h03);
      setp(15'h0000);
      return_from_irq_instr();
      return_from_irq_instr();
      @(posedge core_clk);
      #1;
      chk("in service", in_service, 2'b00);
      slow <= 1'b0;
   endtask

   task automatic test_done();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      src_event = 15'h0000;
      return_from_irq_instr_go   = 1'b0;
      multi     = 1'b0;
      slow      = 1'b0;
      n_errors  = 0;
      comparisons = 0;
      nb        = 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_gate();
      t_clear();
      t_vectors();
      t_prio();
      test_done();
   end

   // Watchdog at 20000 cycles, well beyond the expected several hundred cycles
   initial begin
      #200000;
      n_errors++;
      test_done();
   end
endmodule
`default_nettype wire

/* File: hdl/tlvic_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tlvic_ctrl (
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic [14:0]         src_event,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   input  wire logic                instr_done,
   input  wire logic                instr_multi_next,
   input  wire logic                return_from_irq_instr_done,
   output logic                     call_req,
   input  wire logic                call_ack,
   output tlvic_pkg::tlv_req_type   call_info,
   output logic [14:0]              pending,
   output logic [1:0]               in_service
);
   logic [7:0]               primary_enable_reg_ff;
   logic [7:0]               primary_priority_reg_ff;
   logic [7:0]               extended_enable_reg_ff;
   logic [7:0]               extended_priority_reg_ff;
   logic [14:0]              pend_ff;
   logic [1:0]               insvc_ff;
   logic                     post_return_from_irq_instr_ff;
   logic                     en_clr_ff;
   logic [2:0]               call_cnt_ff;
   tlvic_pkg::tlv_state_type state_ff;
   tlvic_pkg::tlv_req_type   req_ff;
   tlvic_pkg::tlv_req_type   nxt_req;
   logic [14:0]              en_vec;
   logic [14:0]              pri_vec;
   logic [14:0]              active;
   logic                     global_irq_enable;
   logic                     allow_hi;
   logic                     allow_lo;
   logic                     take;
   logic                     clr_en_wr;
   logic [14:0]              nxt_pend;
   logic [1:0]               nxt_insvc;

   // Source bit maps from the four control registers
   always_comb begin
      en_vec  = {extended_enable_reg_ff[7], 1'b0, extended_enable_reg_ff[5:0], primary_enable_reg_ff[6:0]};
      pri_vec = {extended_priority_reg_ff[7], 1'b0, extended_priority_reg_ff[5:0],
                 primary_priority_reg_ff[6:0]};
   end

   assign global_irq_enable = primary_enable_reg_ff[tlvic_pkg::GLB_EN_BIT];
   // Pending is ignored unless both enables are set
   assign active = pend_ff & en_vec & tlvic_pkg::VALID_MASK & {15{global_irq_enable}};

   // Preemption: high only if no high in service, low only if nothing in service
   assign allow_hi = ~insvc_ff[1];
   assign allow_lo = (insvc_ff == 2'b00);

   // Fixed-order pick with high level first; lowest order wins
   function automatic tlvic_pkg::tlv_req_type pick(input logic [14:0] act,
                                                   input logic [14:0] pri,
                                                   input logic ahi,
                                                   input logic alo);
      tlvic_pkg::tlv_req_type r;
      logic [14:0] hi;
      logic [14:0] lo;
      r = '0;
      hi = act & pri & {15{ahi}};
      lo = act & ~pri & {15{alo}};
      for (int i = 14; i >= 0; i--) begin
         if (lo[i]) begin
            r.valid = 1'b1;
            r.high  = 1'b0;
            r.order = 4'(i);
         end
      end
      for (int i = 14; i >= 0; i--) begin
         if (hi[i]) begin
            r.valid = 1'b1;
            r.high  = 1'b1;
            r.order = 4'(i);
         end
      end
      r.vector = tlvic_pkg::VEC_BASE + (16'(r.order) << tlvic_pkg::VEC_SHIFT);
      return r;
   endfunction

   // Decoded every cycle from live state
   assign nxt_req = pick(active, pri_vec, allow_hi, allow_lo);

   // Write to an enable register that clears a bit
   assign clr_en_wr = reg_wr && (((reg_addr == tlvic_pkg::ADDR_PIE) && |(primary_enable_reg_ff & ~reg_wdata))
                   || ((reg_addr == tlvic_pkg::ADDR_XIE) && |(extended_enable_reg_ff & ~reg_wdata)));

   // Vectoring point: end of an instruction, not the one right after return
   assign take = (state_ff == tlvic_pkg::TLV_IDLE) && nxt_req.valid && instr_done
                 && !post_return_from_irq_instr_ff && !(en_clr_ff && instr_multi_next);

   // Enable and priority registers; priorities low after reset
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         primary_enable_reg_ff    <= 8'h00;
         primary_priority_reg_ff  <= 8'h00;
         extended_enable_reg_ff   <= 8'h00;
         extended_priority_reg_ff <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == tlvic_pkg::ADDR_PIE) begin
            primary_enable_reg_ff <= reg_wdata;
         end
         if (reg_addr == tlvic_pkg::ADDR_PPRI) begin
            primary_priority_reg_ff <= reg_wdata & ~tlvic_pkg::PPRI_RD_ONES;
         end
         if (reg_addr == tlvic_pkg::ADDR_XIE) begin
            extended_enable_reg_ff <= reg_wdata & tlvic_pkg::XIE_WMASK;
         end
         if (reg_addr == tlvic_pkg::ADDR_XPRI) begin
            extended_priority_reg_ff <= reg_wdata & tlvic_pkg::XIE_WMASK;
         end
      end
   end

   // Remembers an enable clear until the next instruction boundary
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         en_clr_ff <= 1'b0;
      end else if (clr_en_wr) begin
         en_clr_ff <= 1'b1;
      end else if (instr_done) begin
         en_clr_ff <= 1'b0;
      end
   end

   // Pending flags: events win over software clear and auto-clear
   always_comb begin
      nxt_pend = pend_ff;
      if (reg_wr && reg_addr == tlvic_pkg::ADDR_PEND_LO) begin
         nxt_pend[7:0] = reg_wdata;
      end
      if (reg_wr && reg_addr == tlvic_pkg::ADDR_PEND_HI) begin
         nxt_pend[14:8] = reg_wdata[6:0];
      end
      if (take && tlvic_pkg::HW_CLR_MASK[nxt_req.order]) begin
         nxt_pend[nxt_req.order] = 1'b0;
      end
      nxt_pend = (nxt_pend | src_event) & tlvic_pkg::VALID_MASK;
   end

   // Flag register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pend_ff <= 15'h0000;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // Call sequencer: request, ack, four call cycles
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_ff    <= tlvic_pkg::TLV_IDLE;
         call_cnt_ff <= 3'h0;
         req_ff      <= '0;
      end else begin
         unique case (state_ff)
            tlvic_pkg::TLV_IDLE: begin
               if (take) begin
                  req_ff   <= nxt_req;
                  state_ff <= tlvic_pkg::TLV_HOLD;
               end
            end
            tlvic_pkg::TLV_HOLD: begin
               if (call_ack) begin
                  call_cnt_ff <= 3'h0;
                  state_ff    <= tlvic_pkg::TLV_CALL;
               end
            end
            tlvic_pkg::TLV_CALL: begin
               call_cnt_ff <= call_cnt_ff + 3'h1;
               if (call_cnt_ff == tlvic_pkg::CALL_LAST) begin
                  req_ff   <= '0;
                  state_ff <= tlvic_pkg::TLV_IDLE;
               end
            end
            default: begin
               state_ff <= tlvic_pkg::TLV_IDLE;
            end
         endcase
      end
   end

   // In-service per level; return clears the highest, a vector in the same cycle still sets
   always_comb begin
      nxt_insvc = insvc_ff;
      if (return_from_irq_instr_done) begin
         if (insvc_ff[1]) begin
            nxt_insvc[1] = 1'b0;
         end else begin
            nxt_insvc[0] = 1'b0;
         end
      end
      if (take) begin
         nxt_insvc[nxt_req.high] = 1'b1;
      end
   end

   // In-service register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         insvc_ff <= 2'b00;
      end else begin
         insvc_ff <= nxt_insvc;
      end
   end

   // One instruction must run after a return before re-entry
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         post_return_from_irq_instr_ff <= 1'b0;
      end else if (return_from_irq_instr_done) begin
         post_return_from_irq_instr_ff <= 1'b1;
      end else if (instr_done) begin
         post_return_from_irq_instr_ff <= 1'b0;
      end
   end

   // Register read port, data one cycle after strobe
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            tlvic_pkg::ADDR_PIE:     reg_rdata <= primary_enable_reg_ff;
            tlvic_pkg::ADDR_PPRI:    reg_rdata <= primary_priority_reg_ff | tlvic_pkg::PPRI_RD_ONES;
            tlvic_pkg::ADDR_XIE:     reg_rdata <= extended_enable_reg_ff;
            tlvic_pkg::ADDR_XPRI:    reg_rdata <= extended_priority_reg_ff;
            tlvic_pkg::ADDR_PEND_LO: reg_rdata <= pend_ff[7:0];
            tlvic_pkg::ADDR_PEND_HI: reg_rdata <= {1'b0, pend_ff[14:8]};
            tlvic_pkg::ADDR_STAT:    reg_rdata <= {4'h0, state_ff, insvc_ff};
            default:                 reg_rdata <= 8'h00;
         endcase
      end
   end

   assign call_req   = (state_ff == tlvic_pkg::TLV_HOLD);
   assign call_info  = req_ff;
   assign pending    = pend_ff;
   assign in_service = insvc_ff;

   // Checks
   property p_no_req_disabled;
      @(posedge core_clk) disable iff (!rstn) take |-> global_irq_enable && en_vec[nxt_req.order];
   endproperty
   a_no_req_disabled: assert property (p_no_req_disabled) else $error("vector taken while disabled");

   property p_event_sets;
      @(posedge core_clk) disable iff (!rstn) (src_event != 15'h0000) |=> ((pend_ff & $past(src_event)
         & tlvic_pkg::VALID_MASK) == ($past(src_event) & tlvic_pkg::VALID_MASK));
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event did not set pending");

   property p_hi_not_preempted;
      @(posedge core_clk) disable iff (!rstn) insvc_ff[1] |-> !take;
   endproperty
   a_hi_not_preempted: assert property (p_hi_not_preempted) else $error("high routine preempted");

   property p_low_waits;
      @(posedge core_clk) disable iff (!rstn) (take && insvc_ff[0]) |-> nxt_req.high;
   endproperty
   a_low_waits: assert property (p_low_waits) else $error("equal level nested");

   property p_call_len;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff == tlvic_pkg::TLV_HOLD && call_ack) |=> (state_ff == tlvic_pkg::TLV_CALL) [*4]
         ##1 (state_ff == tlvic_pkg::TLV_IDLE);
   endproperty
   a_call_len: assert property (p_call_len) else $error("call not four cycles");

   property p_vector;
      @(posedge core_clk) disable iff (!rstn) call_req |-> call_info.vector ==
         tlvic_pkg::VEC_BASE + (16'(call_info.order) << tlvic_pkg::VEC_SHIFT) && call_info.order != 4'hd;
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");

   property p_after_return_from_irq_instr;
      @(posedge core_clk) disable iff (!rstn) return_from_irq_instr_done |=> !take;
   endproperty
   a_after_return_from_irq_instr: assert property (p_after_return_from_irq_instr) else $error("no instruction after return");

   property p_hw_clear;
      @(posedge core_clk) disable iff (!rstn)
         (take && nxt_req.order > 4'h3 && !reg_wr) |=> pend_ff[$past(nxt_req.order)];
   endproperty
   a_hw_clear: assert property (p_hw_clear) else $error("software-cleared flag dropped");

   property p_multi_block;
      @(posedge core_clk) disable iff (!rstn) (en_clr_ff && instr_multi_next) |-> !take;
   endproperty
   a_multi_block: assert property (p_multi_block) else $error("taken after enable clear");

   property p_level_order;
      @(posedge core_clk) disable iff (!rstn) (take && !nxt_req.high) |-> (active & pri_vec) == 15'h0000 || !allow_hi;
   endproperty
   a_level_order: assert property (p_level_order) else $error("low beat high");

   property p_global_gate;
      @(posedge core_clk) disable iff (!rstn)
         !global_irq_enable |-> !take;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("vector with global enable off");

   property p_req_stands;
      @(posedge core_clk) disable iff (!rstn)
         (call_req && !call_ack) |=> call_req;
   endproperty
   a_req_stands: assert property (p_req_stands) else $error("call request dropped before ack");

   property p_info_held;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff != tlvic_pkg::TLV_IDLE) |=> (state_ff == tlvic_pkg::TLV_IDLE) || $stable(call_info);
   endproperty
   a_info_held: assert property (p_info_held) else $error("call info changed mid call");

   // Quiet cycle needed, an event or a write may legally refill the flag
   property p_auto_clear;
      @(posedge core_clk) disable iff (!rstn)
         (take && tlvic_pkg::HW_CLR_MASK[nxt_req.order] && src_event == 15'h0000 && !reg_wr)
         |=> !pend_ff[$past(nxt_req.order)];
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("auto-clear flag left set");

   property p_level_free;
      @(posedge core_clk) disable iff (!rstn)
         take |-> !insvc_ff[nxt_req.high];
   endproperty
   a_level_free: assert property (p_level_free) else $error("vector into a busy level");

   property p_insvc_set;
      @(posedge core_clk) disable iff (!rstn)
         take |=> insvc_ff[$past(nxt_req.high)];
   endproperty
   a_insvc_set: assert property (p_insvc_set) else $error("in-service not set on vector");

   property p_return_from_irq_instr_high;
      @(posedge core_clk) disable iff (!rstn)
         (return_from_irq_instr_done && !take && insvc_ff[1]) |=> !insvc_ff[1] && (insvc_ff[0] == $past(insvc_ff[0]));
   endproperty
   a_return_from_irq_instr_high: assert property (p_return_from_irq_instr_high) else $error("return did not clear high level");

   property p_return_from_irq_instr_low;
      @(posedge core_clk) disable iff (!rstn)
         (return_from_irq_instr_done && !take && insvc_ff == 2'b01) |=> (insvc_ff == 2'b00);
   endproperty
   a_return_from_irq_instr_low: assert property (p_return_from_irq_instr_low) else $error("return did not clear low level");

   property p_call_follows;
      @(posedge core_clk) disable iff (!rstn)
         take |=> call_req && call_info.valid;
   endproperty
   a_call_follows: assert property (p_call_follows) else $error("no call request after vector");

   property p_decode_now;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff == tlvic_pkg::TLV_IDLE && instr_done && nxt_req.valid && !post_return_from_irq_instr_ff && !en_clr_ff) |-> take;
   endproperty
   a_decode_now: assert property (p_decode_now) else $error("boundary passed with request");

   // A single-cycle follower after an enable clear may still vector
   property p_single_ok;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff == tlvic_pkg::TLV_IDLE && instr_done && nxt_req.valid && !post_return_from_irq_instr_ff
          && en_clr_ff && !instr_multi_next) |-> take;
   endproperty
   a_single_ok: assert property (p_single_ok) else $error("single-cycle follower blocked");

   property p_cnt_range;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff == tlvic_pkg::TLV_CALL) |-> (call_cnt_ff <= tlvic_pkg::CALL_LAST);
   endproperty
   a_cnt_range: assert property (p_cnt_range) else $error("call counter overran");

   // No lower order of the chosen level may be active
   property p_order_win;
      @(posedge core_clk) disable iff (!rstn)
         take |-> ((active & (nxt_req.high ? pri_vec : ~pri_vec))
         & ((15'h0001 << nxt_req.order) - 15'h0001)) == 15'h0000;
   endproperty
   a_order_win: assert property (p_order_win) else $error("later order beat earlier");
endmodule
`default_nettype wire

/* File: hdl/tlvic_pkg.sv */
// Function
// - Fourteen sources, each low or high priority
// - Pending flag sets regardless of enables
// - Enabled pending source forces long call vector
// - Disabled source makes no request
// - Global enable bit gates all sources
// - Per-source enable and priority bits
// - Enable clear blocks request before multi-cycle
// - Hardware clears only four flags on vectoring
// - Flag still set after return re-requests
// - Software-set flag behaves like hardware one
// - High preempts low, high never preempted
// - All sources low priority after reset
// - Higher level wins, then lower order
// - Sample and decode every cycle
// - One instruction runs after return first
// - Worst latency return plus divide
// - Equal or lower waits for routine end
// - Vectors from 0x0003 step eight, 13 reserved
`default_nettype none
package tlvic_pkg;
   localparam int unsigned NUM_SRC   = 15;          // Order slots 0..14, slot 13 reserved
   localparam int unsigned RSVD_SLOT = 13;
   localparam int unsigned REG_AW    = 8;
   localparam logic [7:0]  ADDR_PIE  = 8'ha8;       // Primary enable
   localparam logic [7:0]  ADDR_PPRI = 8'hb8;       // Primary priority
   localparam logic [7:0]  ADDR_XIE  = 8'he6;       // Extended enable
   localparam logic [7:0]  ADDR_XPRI = 8'hf6;       // Extended priority
   localparam logic [7:0]  ADDR_PEND_LO = 8'hc0;    // Pending flags 0..7
   localparam logic [7:0]  ADDR_PEND_HI = 8'hc1;    // Pending flags 8..14
   localparam logic [7:0]  ADDR_STAT = 8'hc2;       // In-service and state
   localparam int unsigned GLB_EN_BIT = 7;
   localparam logic [7:0]  PPRI_RD_ONES = 8'h80;    // Unused top bit reads one
   localparam logic [7:0]  XIE_WMASK = 8'hbf;       // Reserved bit 6 not stored
   localparam logic [14:0] HW_CLR_MASK = 15'h000f;  // Orders 0..3 auto-clear
   localparam logic [14:0] VALID_MASK  = 15'h5fff;  // Slot 13 masked off
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam int unsigned VEC_SHIFT = 3;           // Eight bytes per slot
   localparam int unsigned CALL_CYCLES = 4;
   localparam logic [2:0]  CALL_LAST = 3'h3;
   typedef enum logic [1:0] {
      TLV_IDLE  = 2'b00,
      TLV_CALL  = 2'b01,
      TLV_HOLD  = 2'b10
   } tlv_state_type;
   typedef struct packed {
      logic        valid;
      logic        high;
      logic [3:0]  order;
      logic [15:0] vector;
   } tlv_req_type;
endpackage
`default_nettype wire
